// ### rtl/modem_port_params.svh
// Offsets, field positions and used-bit masks for the modem port and status-change block
`ifndef MODEM_PORT_PARAMS_SVH
`define MODEM_PORT_PARAMS_SVH
`define MP_OFF_CTRL        9'h080
`define MP_OFF_EVENT       9'h0f0
`define MP_OFF_MASK        9'h0f4
`define MP_OFF_PRESENT     9'h0f8
`define MP_OFF_FORCE       9'h0fc
`define MP_CHIPSET_LAST    9'h00f
`define MP_FUNC_BASE       9'h080
`define MP_CIS_BASE        9'h100
`define MP_IRQ_BIT         15
`define MP_WAKE_BIT        14
`define MP_GENERAL_WAKE_MASK_BIT_BIT       4
`define MP_CTRL_RST_BIT    0
`define MP_CTRL_CSM_BIT    1
`define MP_MASK_USED       32'h0000_c010
`define MP_EVENT_USED      32'h0000_8010
`define MP_CTRL_USED       32'h0000_0003
`define MP_CIS_WORDS       64
`endif

// ### rtl/modem_port_pkg.sv
// Types shared by the modem port and status-change block
package modem_port_pkg;
    typedef enum logic [1:0] {
        SPACE_NONE,
        SPACE_MEM,
        SPACE_IO
    } space_t;

    typedef struct packed {
        logic        valid;
        space_t      space;
        logic        write;
        logic [8:0]  offset;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [3:0]  addr;
        logic [7:0]  wdata;
    } modem_cyc_t;

    typedef enum logic [1:0] {
        DEC_CHIPSET,
        DEC_FUNC,
        DEC_CIS,
        DEC_NONE
    } decode_t;
endpackage

// ### rtl/modem_port_and_status_change.sv
// Modem window decode, modem cycle forwarding and CardBus status-change registers
//
// Functional notes
// - Forward window accesses onto four-bit modem bus
// - Offsets 0..F external, 80..FF internal registers
// - Offsets 100..1FF return loaded card information
// - Control: bit0 modem reset, bit1 central-site
// - Event F0, mask F4, present F8, force FC
// - 0..7 mimic port, 8..F resource port
// - I/O window cycles are single bytes only
// - I/O: top line low, low lines offset
// - Status-change registers act in CardBus mode only
// - Only interrupt and wake event bits exist
// - Status-change registers reset by alternate reset
// - Mask bit 15 clear suppresses modem interrupt
// - Interrupt needs mask and control block enable
// - Mask ignored for interrupt until host writes
// - Mask bit 14 clear blocks wake status change, not PME
// - Wake mask conditioned on general wake bit
// - Mask bits 31..16 reserved, read zero
// - Status change: wake and general, or PME
// - Present bit 15 mirrors modem interrupt pin
// - Present bit 4 mirrors inverted ring pin
`timescale 1ns/1ps
`include "modem_port_params.svh"

module modem_port_and_status_change #(
    parameter int CIS_WORDS = `MP_CIS_WORDS
) (
    input  wire logic                     i_mclk,
    input  wire logic                     i_resetn,
    input  wire logic                     i_alt_powerup_reset_n,
    input  wire logic                     i_cardbus_mode,
    input  wire logic                     i_scb_modem_irq_en,
    input  wire logic                     i_pme_enable,
    input  wire modem_port_pkg::host_req_t i_req,
    input  wire logic                     i_cis_load_valid,
    input  wire logic [5:0]               i_cis_load_index,
    input  wire logic [31:0]              i_cis_load_data,
    input  wire logic                     i_modem_irq_input,
    input  wire logic                     i_modem_ring_input_n,
    input  wire logic                     i_modem_done,
    input  wire logic [7:0]               i_modem_rdata,
    output logic                          o_ack,
    output logic [31:0]                   o_rdata,
    output modem_port_pkg::modem_cyc_t    o_modem_cyc,
    output logic                          o_modem_rst,
    output logic                          o_central_site_mode,
    output logic                          o_inta_req,
    output logic                          o_cstschg
);
    import modem_port_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MODEM,
        ST_DONE
    } state_t;

    // Window decode, used for both the bus response and the register writes
    function automatic decode_t decode_offset(input logic [8:0] off);
        if (off <= `MP_CHIPSET_LAST) begin
            return DEC_CHIPSET;
        end else if (off >= `MP_CIS_BASE) begin
            return DEC_CIS;
        end else if (off >= `MP_FUNC_BASE) begin
            return DEC_FUNC;
        end
        return DEC_NONE;
    endfunction

    // Lowest enabled byte lane; I/O cycles move only that single byte
    function automatic logic [1:0] first_lane(input logic [3:0] be);
        if (be[0]) begin
            return 2'h0;
        end else if (be[1]) begin
            return 2'h1;
        end else if (be[2]) begin
            return 2'h2;
        end
        return 2'h3;
    endfunction

    // Pin synchronisers: pins come from the modem, outside our clock
    logic [1:0] irq_sync_reg, irq_sync_next;
    logic [1:0] ring_sync_reg, ring_sync_next;
    logic [1:0] alt_powerup_reset_n_sync_reg, alt_powerup_reset_n_sync_next;

    always_comb begin
        irq_sync_next    = {irq_sync_reg[0], i_modem_irq_input};
        ring_sync_next   = {ring_sync_reg[0], i_modem_ring_input_n};
        alt_powerup_reset_n_sync_next = {alt_powerup_reset_n_sync_reg[0], i_alt_powerup_reset_n};
    end

    // No bus reset here: it would fake a pin edge or clear status-change state
    always_ff @(posedge i_mclk) begin
        irq_sync_reg    <= irq_sync_next;
        ring_sync_reg   <= ring_sync_next;
        alt_powerup_reset_n_sync_reg <= alt_powerup_reset_n_sync_next;
    end

    wire logic irq_pin    = irq_sync_reg[1];
    wire logic ring_pin   = ~ring_sync_reg[1];
    wire logic alt_rst_n  = alt_powerup_reset_n_sync_reg[1];

    // Card information structure, filled from the serial configuration memory
    logic [31:0] cis_mem [CIS_WORDS];

    always_ff @(posedge i_mclk) begin
        if (i_cis_load_valid) begin
            cis_mem[i_cis_load_index] <= i_cis_load_data;
        end
    end

    // Present state: live view of the modem pins
    logic [31:0] present;

    always_comb begin
        present                = 32'h0;
        present[`MP_IRQ_BIT]   = irq_pin;
        present[`MP_GENERAL_WAKE_MASK_BIT_BIT] = ring_pin;
    end

    // Bus sequencer and status-change registers
    state_t      state_reg, state_next;
    modem_cyc_t  cyc_reg, cyc_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  ctrl_reg, ctrl_next;
    logic [31:0] event_reg, event_next;
    logic [31:0] mask_reg, mask_next;
    logic        mask_written_reg, mask_written_next;
    logic [1:0]  lane_reg, lane_next;
    logic        irq_edge_reg, irq_edge_next;
    logic        ring_edge_reg, ring_edge_next;

    decode_t    dec;
    logic       sc_wr;
    logic [31:0] wmask;
    logic [1:0] lane;
    logic [31:0] ev_set;

    always_comb begin
        state_next        = state_reg;
        cyc_next          = cyc_reg;
        rdata_next        = rdata_reg;
        ctrl_next         = ctrl_reg;
        event_next        = event_reg;
        mask_next         = mask_reg;
        mask_written_next = mask_written_reg;
        lane_next         = lane_reg;
        irq_edge_next     = irq_pin;
        ring_edge_next    = ring_pin;
        dec               = decode_offset(i_req.offset);
        lane              = first_lane(i_req.byte_en);
        wmask             = {{8{i_req.byte_en[3]}}, {8{i_req.byte_en[2]}},
                             {8{i_req.byte_en[1]}}, {8{i_req.byte_en[0]}}};
        sc_wr             = 1'b0;
        ev_set            = 32'h0;
        o_ack             = 1'b0;

        // Pin rising edges record events regardless of masks
        ev_set[`MP_IRQ_BIT]   = irq_pin & ~irq_edge_reg;
        ev_set[`MP_GENERAL_WAKE_MASK_BIT_BIT] = ring_pin & ~ring_edge_reg;

        case (state_reg)
            ST_IDLE: begin
                if (i_req.valid && i_req.space == SPACE_IO) begin
                    // Single byte at the lowest lane, top line held low
                    cyc_next.valid = 1'b1;
                    cyc_next.write = i_req.write;
                    cyc_next.addr  = {1'b0, i_req.offset[2:0]};
                    cyc_next.wdata = i_req.wdata[8*lane +: 8];
                    lane_next      = lane;
                    state_next     = ST_MODEM;
                end else if (i_req.valid && i_req.space == SPACE_MEM) begin
                    case (dec)
                        DEC_CHIPSET: begin
                            cyc_next.valid = 1'b1;
                            cyc_next.write = i_req.write;
                            cyc_next.addr  = i_req.offset[3:0];
                            cyc_next.wdata = i_req.wdata[8*lane +: 8];
                            lane_next      = lane;
                            state_next     = ST_MODEM;
                        end
                        DEC_CIS: begin
                            rdata_next = cis_mem[i_req.offset[7:2]];
                            state_next = ST_DONE;
                        end
                        DEC_FUNC: begin
                            sc_wr      = i_req.write;
                            state_next = ST_DONE;
                            case ({i_req.offset[8:2], 2'b00})
                                `MP_OFF_CTRL: begin
                                    rdata_next = {30'h0, ctrl_reg};
                                    if (i_req.write) begin
                                        ctrl_next = (i_req.wdata[1:0] & wmask[1:0]) |
                                                    (ctrl_reg & ~wmask[1:0]);
                                    end
                                end
                                `MP_OFF_EVENT:   rdata_next = event_reg;
                                `MP_OFF_MASK:    rdata_next = mask_reg;
                                `MP_OFF_PRESENT: rdata_next = present;
                                default:         rdata_next = 32'h0; // Force is write-only
                            endcase
                        end
                        default: begin
                            rdata_next = 32'h0; // Unused offsets read zero
                            state_next = ST_DONE;
                        end
                    endcase
                end
            end
            ST_MODEM: begin
                // Hold the modem cycle until the chipset completes it
                if (i_modem_done) begin
                    cyc_next.valid = 1'b0;
                    rdata_next     = 32'h0;
                    rdata_next[8*lane_reg +: 8] = i_modem_rdata;
                    state_next     = ST_DONE;
                end
            end
            ST_DONE: begin
                o_ack      = 1'b1;
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase

        // Status-change writes, only honoured in CardBus mode
        if (sc_wr && i_cardbus_mode) begin
            case ({i_req.offset[8:2], 2'b00})
                `MP_OFF_EVENT: begin
                    event_next = event_reg & ~(i_req.wdata & wmask & `MP_EVENT_USED);
                end
                `MP_OFF_MASK: begin
                    mask_next = ((i_req.wdata & wmask) | (mask_reg & ~wmask))
                                & `MP_MASK_USED;
                    mask_written_next = 1'b1;
                end
                `MP_OFF_FORCE: begin
                    ev_set = ev_set | (i_req.wdata & wmask);
                end
                default: ;
            endcase
        end
        // Set wins over a simultaneous clear
        if (i_cardbus_mode) begin
            event_next = event_next | (ev_set & `MP_EVENT_USED);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            state_reg     <= ST_IDLE;
            cyc_reg       <= '0;
            rdata_reg     <= 32'h0;
            ctrl_reg      <= 2'h0;
            lane_reg      <= 2'h0;
        end else begin
            state_reg     <= state_next;
            cyc_reg       <= cyc_next;
            rdata_reg     <= rdata_next;
            ctrl_reg      <= ctrl_next;
            lane_reg      <= lane_next;
        end
    end

    // Status-change state survives the bus reset; only the power-up reset clears it
    always_ff @(posedge i_mclk) begin
        if (!alt_rst_n) begin
            event_reg        <= 32'h0;
            mask_reg         <= 32'h0;
            mask_written_reg <= 1'b0;
            irq_edge_reg     <= irq_pin;  // Follow the pin so release fakes no edge
            ring_edge_reg    <= ring_pin;
        end else begin
            event_reg        <= event_next;
            mask_reg         <= mask_next;
            mask_written_reg <= mask_written_next;
            irq_edge_reg     <= irq_edge_next;
            ring_edge_reg    <= ring_edge_next;
        end
    end

    // Interrupt and status-change outputs
    logic irq_gate;
    logic inta_reg, cstschg_reg;

    always_comb begin
        irq_gate = mask_reg[`MP_IRQ_BIT] | ~mask_written_reg | ~i_cardbus_mode;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            inta_reg    <= 1'b0;
            cstschg_reg <= 1'b0;
        end else begin
            inta_reg    <= irq_pin & irq_gate & i_scb_modem_irq_en;
            cstschg_reg <= i_cardbus_mode &
                           ((event_reg[`MP_GENERAL_WAKE_MASK_BIT_BIT] & mask_reg[`MP_WAKE_BIT] &
                             mask_reg[`MP_GENERAL_WAKE_MASK_BIT_BIT]) | i_pme_enable);
        end
    end

    assign o_modem_cyc         = cyc_reg;
    assign o_rdata             = rdata_reg;
    assign o_modem_rst         = ctrl_reg[`MP_CTRL_RST_BIT];
    assign o_central_site_mode = ctrl_reg[`MP_CTRL_CSM_BIT];
    assign o_inta_req          = inta_reg;
    assign o_cstschg           = cstschg_reg;
endmodule

// ### verif/modem_chipset_model.sv
// Behavioural model of the external modem chipset on the four-bit address bus
`timescale 1ns/1ps
module modem_chipset_model (
    input  wire logic                       i_mclk,
    input  wire modem_port_pkg::modem_cyc_t i_cyc,
    input  wire logic [3:0]                 i_wait,
    output logic                            o_done,
    output logic [7:0]                      o_rdata
);
    import modem_port_pkg::*;
    logic [7:0] port_mem [16];
    logic [3:0] cnt;
    initial begin
        cnt = 4'h0;
        o_done = 1'b0;
        o_rdata = 8'h5a;
    end
    // Answer after i_wait cycles; data toggles when idle so stale bytes never match
    always @(posedge i_mclk) begin
        o_done <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_cyc.valid && !o_done) begin
            cnt <= (cnt == i_wait) ? 4'h0 : cnt + 4'h1;
            if (cnt == i_wait) begin
                o_done <= 1'b1;
                if (i_cyc.write) port_mem[i_cyc.addr] <= i_cyc.wdata;
                else o_rdata <= port_mem[i_cyc.addr];
            end
        end
    end
endmodule

// ### verif/modem_port_and_status_change_asserts.sv
// Port-level assertions for the modem port and status-change block
`timescale 1ns/1ps
module modem_port_and_status_change_asserts (
    input wire logic                       i_mclk,
    input wire logic                       i_resetn,
    input wire logic                       i_cardbus_mode,
    input wire logic                       i_scb_modem_irq_en,
    input wire logic                       i_pme_enable,
    input wire modem_port_pkg::host_req_t  i_req,
    input wire logic                       i_modem_done,
    input wire logic                       o_ack,
    input wire modem_port_pkg::modem_cyc_t o_modem_cyc,
    input wire logic                       o_inta_req,
    input wire logic                       o_cstschg
);
    import modem_port_pkg::*;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    // Modem bus address follows the host offset
    property p_mem_addr;
        o_modem_cyc.valid && i_req.space == SPACE_MEM |-> o_modem_cyc.addr == i_req.offset[3:0];
    endproperty
    property p_io_addr;
        o_modem_cyc.valid && i_req.space == SPACE_IO |-> o_modem_cyc.addr == {1'b0, i_req.offset[2:0]};
    endproperty
    // Internal offsets never leave the device
    property p_internal;
        i_req.valid && i_req.space == SPACE_MEM && i_req.offset[8:7] != 2'b00 |-> !o_modem_cyc.valid;
    endproperty
    property p_reg_ack;
        $rose(i_req.valid) && i_req.space == SPACE_MEM && i_req.offset[8:7] != 2'b00 |=> o_ack;
    endproperty
    // Cycle holds until the chipset finishes, then the host is answered
    property p_hold;
        o_modem_cyc.valid && !i_modem_done |=> $stable(o_modem_cyc);
    endproperty
    property p_done;
        o_modem_cyc.valid && i_modem_done |=> !o_modem_cyc.valid && o_ack ##1 !o_ack;
    endproperty
    // Output gating by the control-block enable and the bus mode
    property p_inta;
        o_inta_req |-> $past(i_scb_modem_irq_en);
    endproperty
    property p_cstschg;
        o_cstschg |-> $past(i_cardbus_mode);
    endproperty
    property p_pme;
        i_pme_enable && i_cardbus_mode |=> o_cstschg;
    endproperty
    a_mem_addr: assert property (p_mem_addr) else $error("modem address differs from offset");
    a_io_addr: assert property (p_io_addr) else $error("io modem address wrong");
    a_internal: assert property (p_internal) else $error("internal offset forwarded");
    a_reg_ack: assert property (p_reg_ack) else $error("register access not acked");
    a_hold: assert property (p_hold) else $error("modem cycle changed early");
    a_done: assert property (p_done) else $error("modem cycle end wrong");
    a_inta: assert property (p_inta) else $error("interrupt without enable");
    a_cstschg: assert property (p_cstschg) else $error("status change outside mode");
    a_pme: assert property (p_pme) else $error("pme did not raise status change");
    c_modem: cover property (o_modem_cyc.valid && i_modem_done);
    c_cstschg: cover property ($rose(o_cstschg));
    c_inta: cover property ($rose(o_inta_req));
endmodule

bind modem_port_and_status_change modem_port_and_status_change_asserts chk_u (
    .i_mclk, .i_resetn, .i_cardbus_mode, .i_scb_modem_irq_en, .i_pme_enable, .i_req,
    .i_modem_done, .o_ack, .o_modem_cyc, .o_inta_req, .o_cstschg
);

// ### verif/tb_modem_port_and_status_change.sv
// Self-checking bench for the modem port and status-change block
`timescale 1ns/1ps
module tb_modem_port_and_status_change;
    import modem_port_pkg::*;
    logic        i_mclk = 0, i_resetn, i_alt_powerup_reset_n, i_cardbus_mode;
    logic        i_scb_modem_irq_en, i_pme_enable, i_cis_load_valid, i_modem_irq_input;
    logic        i_modem_ring_input_n, i_modem_done, o_ack, o_modem_rst;
    logic        o_central_site_mode, o_inta_req, o_cstschg;
    logic [5:0]  i_cis_load_index;
    logic [31:0] i_cis_load_data, o_rdata, rd;
    logic [7:0]  i_modem_rdata;
    logic [3:0]  wait_cycles;
    host_req_t   i_req;
    modem_cyc_t  o_modem_cyc;
    int          n_mismatch = 0, n_checks = 0, cyc_count = 0;

    modem_port_and_status_change dut_u (
        .i_mclk, .i_resetn, .i_alt_powerup_reset_n, .i_cardbus_mode, .i_scb_modem_irq_en,
        .i_pme_enable, .i_req, .i_cis_load_valid, .i_cis_load_index, .i_cis_load_data,
        .i_modem_irq_input, .i_modem_ring_input_n, .i_modem_done, .i_modem_rdata, .o_ack,
        .o_rdata, .o_modem_cyc, .o_modem_rst, .o_central_site_mode, .o_inta_req, .o_cstschg
    );
    modem_chipset_model modem_u (
        .i_mclk(i_mclk), .i_cyc(o_modem_cyc), .i_wait(wait_cycles),
        .o_done(i_modem_done), .o_rdata(i_modem_rdata)
    );

    always #4 i_mclk = ~i_mclk;

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Whole run needs about 400 cycles; the ceiling leaves wide margin
    always @(posedge i_mclk) begin
        cyc_count++;
        if (cyc_count == 5000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // One host access held until ack; an idle edge follows so valid never re-rises at once
    task automatic acc(input space_t sp, input logic wr, input logic [8:0] off,
                       input logic [3:0] be, input logic [31:0] wd);
        int n;
        i_req <= '{1'b1, sp, wr, off, be, wd};
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_ack !== 1'b1 && n < 50);
        if (n == 50) chk("ack", 32'h1, 32'h0);
        rd = o_rdata;
        i_req <= '0;
        @(posedge i_mclk);
    endtask

    task automatic wreg(input logic [8:0] off, input logic [31:0] d);
        acc(SPACE_MEM, 1'b1, off, 4'hf, d);
    endtask

    task automatic rchk(input string nm, input logic [8:0] off, input logic [31:0] e);
        acc(SPACE_MEM, 1'b0, off, 4'hf, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic settle();
        repeat (5) @(posedge i_mclk);
    endtask

    initial begin
        {i_resetn, i_alt_powerup_reset_n, i_pme_enable, i_cis_load_valid} = 4'h0;
        {i_cardbus_mode, i_scb_modem_irq_en, i_modem_ring_input_n} = 3'b111;
        i_modem_irq_input = 1'b0;
        i_cis_load_index = 6'h01;
        i_cis_load_data = 32'h1234_5678;
        i_req = '0;
        wait_cycles = 4'h0;
        repeat (5) @(posedge i_mclk);
        i_resetn <= 1'b1;
        i_alt_powerup_reset_n <= 1'b1;
        i_cis_load_valid <= 1'b1;
        @(posedge i_mclk);
        i_cis_load_valid <= 1'b0;
        // Card information area is loaded, not host written
        rchk("cis", 9'h104, 32'h1234_5678);
        wreg(9'h104, 32'h0);
        rchk("cis kept", 9'h104, 32'h1234_5678);
        wreg(9'h080, 32'h3);
        chk("ctrl pins", 32'h3, {30'h0, o_central_site_mode, o_modem_rst});
        rchk("ctrl", 9'h080, 32'h3);
        rchk("unmapped", 9'h020, 32'h0);
        // All sixteen chipset ports, each lane, prompt and slow answers
        for (int i = 0; i < 16; i++) begin
            wait_cycles <= 4'(i % 4);
            acc(SPACE_MEM, 1'b1, 9'(i), 4'h1 << (i % 4), {4{8'h30 + 8'(i)}});
        end
        for (int i = 0; i < 16; i++) begin
            acc(SPACE_MEM, 1'b0, 9'(i), 4'h1 << (i % 4), 32'h0);
            chk("modem byte", 32'(8'h30 + 8'(i)), (rd >> (8 * (i % 4))) & 32'hff);
        end
        acc(SPACE_IO, 1'b1, 9'h002, 4'h4, {4{8'ha5}});
        acc(SPACE_MEM, 1'b0, 9'h002, 4'h4, 32'h0);
        chk("io write", 32'ha5, (rd >> 16) & 32'hff);
        acc(SPACE_IO, 1'b0, 9'h00a, 4'h4, 32'h0);
        chk("io read", 32'ha5, (rd >> 16) & 32'hff);
        // Events, mask and present state
        i_modem_irq_input <= 1'b1;
        settle();
        chk("inta unmasked", 32'h1, 32'(o_inta_req));
        rchk("present irq", 9'h0f8, 32'h0000_8000);
        i_modem_ring_input_n <= 1'b0;
        settle();
        rchk("present ring", 9'h0f8, 32'h0000_8010);
        rchk("event", 9'h0f0, 32'h0000_8010);
        wreg(9'h0f4, 32'hffff_ffff);
        rchk("mask", 9'h0f4, 32'h0000_c010);
        settle();
        chk("cstschg on", 32'h1, 32'(o_cstschg));
        wreg(9'h0f4, 32'h0000_c000);
        settle();
        chk("cstschg general_wake_mask_bit", 32'h0, 32'(o_cstschg));
        wreg(9'h0f4, 32'h0000_0010);
        settle();
        chk("cstschg wake", 32'h0, 32'(o_cstschg));
        chk("inta masked", 32'h0, 32'(o_inta_req));
        rchk("event kept", 9'h0f0, 32'h0000_8010);
        i_pme_enable <= 1'b1;
        settle();
        chk("cstschg pme", 32'h1, 32'(o_cstschg));
        i_pme_enable <= 1'b0;
        wreg(9'h0f0, 32'hffff_ffff);
        rchk("event clear", 9'h0f0, 32'h0);
        wreg(9'h0fc, 32'hffff_ffff);
        rchk("event force", 9'h0f0, 32'h0000_8010);
        wreg(9'h0f4, 32'h0000_8000);
        i_scb_modem_irq_en <= 1'b0;
        settle();
        chk("inta scb off", 32'h0, 32'(o_inta_req));
        i_scb_modem_irq_en <= 1'b1;
        settle();
        chk("inta scb on", 32'h1, 32'(o_inta_req));
        i_cardbus_mode <= 1'b0;
        wreg(9'h0f4, 32'h0);
        i_cardbus_mode <= 1'b1;
        rchk("mask not cardbus", 9'h0f4, 32'h0000_8000);
        // Alternate reset clears status change only
        wreg(9'h080, 32'h2);
        i_alt_powerup_reset_n <= 1'b0;
        settle();
        i_alt_powerup_reset_n <= 1'b1;
        settle();
        rchk("mask alt", 9'h0f4, 32'h0);
        rchk("ctrl alt", 9'h080, 32'h2);
        chk("inta alt", 32'h1, 32'(o_inta_req));
        // Bus reset in mid-run keeps status-change state and fakes no pin edge
        wreg(9'h0f4, 32'h0000_8000);
        i_resetn <= 1'b0;
        settle();
        i_resetn <= 1'b1;
        settle();
        rchk("mask bus rst", 9'h0f4, 32'h0000_8000);
        rchk("event bus rst", 9'h0f0, 32'h0);
        rchk("ctrl bus rst", 9'h080, 32'h0);
        test_done();
    end
endmodule
